/* pkg/tws_pkg.sv */
// shared constants and types for the three-wire serial eeprom link
package tws_pkg;
  // clocks and link timing
  localparam int CORE_HZ = 50_000_000;
  localparam int SK_MAX_HZ = 2_000_000;
  localparam int SK_HALF_CYC = (CORE_HZ + 2 * SK_MAX_HZ - 1) / (2 * SK_MAX_HZ);
  localparam int TCS_NS = 250;
  localparam int TCS_CYC = (TCS_NS * (CORE_HZ / 1_000_000) + 999) / 1000;
  localparam int TSV_NS = 250;
  localparam int TSV_CYC = (TSV_NS * (CORE_HZ / 1_000_000) + 999) / 1000;
  localparam int TWP_MAX_MS = 10;
  localparam int TWP_MAX_CYC = TWP_MAX_MS * (CORE_HZ / 1000);
  localparam int TWP_TYP_MS = 3;
  localparam int TWP_TYP_CYC = TWP_TYP_MS * (CORE_HZ / 1000);
  // array shape
  localparam int ARRAY_BITS = 1024;
  localparam int NUM_BYTES = 128;
  localparam int NUM_WORDS = 64;
  localparam int AW_X8 = 7;
  localparam int AW_X16 = 6;
  localparam int DW_X8 = 8;
  localparam int DW_X16 = 16;
  localparam int FRAME_W = 27;
  localparam logic START_MARKER = 1'b1;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // opcode field
  typedef enum logic [1:0] {
    TWS_OP_EXT = 2'b00,
    TWS_OP_WRITE = 2'b01,
    TWS_OP_READ = 2'b10,
    TWS_OP_ERASE = 2'b11
  } tws_op_e;
  // top two address bits under the extended opcode
  typedef enum logic [1:0] {
    TWS_EXT_DISABLE = 2'b00,
    TWS_EXT_WRITE_ALL = 2'b01,
    TWS_EXT_ERASE_ALL = 2'b10,
    TWS_EXT_ENABLE = 2'b11
  } tws_ext_e;
  // host user commands
  typedef enum logic [2:0] {
    TWS_CMD_READ = 3'h0,
    TWS_CMD_ENABLE = 3'h1,
    TWS_CMD_DISABLE = 3'h2,
    TWS_CMD_ERASE = 3'h3,
    TWS_CMD_WRITE = 3'h4,
    TWS_CMD_ERASE_ALL = 3'h5,
    TWS_CMD_WRITE_ALL = 3'h6
  } tws_cmd_e;
endpackage : tws_pkg

/* pkg/tws_link_if.sv */
// three-wire link between host and eeprom, with pulled-up data out
`timescale 1ns/1ps
interface tws_link_if;
  logic cs;
  logic sk;
  logic di;
  logic do_val;
  logic do_oe;
  logic do_line;
  // undriven data out line reads high
  assign do_line = do_oe ? do_val : 1'b1;
  modport dev (input cs, input sk, input di, output do_val, output do_oe);
  modport host (output cs, output sk, output di, input do_line);
endinterface : tws_link_if

/* core/tws_eeprom_dev.sv */
// eeprom end of the three-wire link: decoder, array and self-timed programming
//
// What this block does
// RULE1 - 1024 bits as 64x16 or 128x8
// RULE2 - read: start, 10, address, word shifted out
// RULE3 - enable: 00 then 11, before programming
// RULE4 - erase: 11 plus address erases location
// RULE5 - write: 01, address, data programs location
// RULE6 - erase all: 00 then 10
// RULE7 - write all: 00, 01, data everywhere
// RULE8 - disable: 00 then 00, blocks programming
// RULE9 - host clocks every don't-care address bit
// RULE10 - self-timed programming, no erase needed first
// RULE11 - programming only while enabled
// RULE12 - select raised again shows ready or busy
// RULE13 - programming finishes within 10 ms
// RULE14 - host shift clock at most 2 MHz
// RULE15 - zero dummy bit precedes read data
// RULE16 - power-up in programming-disabled state
// RULE17 - erase sets affected bits to one
// RULE18 - status low busy, high when done
// RULE19 - msb first, sampled on shift clock rise
`timescale 1ns/1ps
module tws_eeprom_dev #(
  parameter int PROG_CYCLES = tws_pkg::TWP_TYP_CYC
) (
  // link
  tws_link_if.dev lnk,
  // internal timing clock and power-up reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // strap: high selects 16-bit words
  input wire logic organization_select_i,
  // status
  output logic busy_o
);
  localparam int CW = $clog2(PROG_CYCLES + 1);
  localparam logic [CW-1:0] PROG_LAST = CW'(PROG_CYCLES - 1);

  // frame state, cleared whenever select is low
  typedef struct packed {
    logic started;
    logic done;
    logic [4:0] n;
    logic [23:0] sh;
    logic rd_act;
    logic [16:0] rd_sh;
    logic go;
    logic en;
    logic ds;
  } tws_frame_s;

  // timing-domain state
  typedef struct packed {
    logic [5:0] m;
    logic [5:0] s;
    logic cs_q;
    logic go_q;
    logic en_q;
    logic ds_q;
    logic wen;
    logic busy;
    logic stat;
    logic [CW-1:0] cnt;
    logic do_q;
    logic oe_q;
  } tws_core_s;

  tws_frame_s fq;
  tws_frame_s next_fq;
  tws_core_s cq;
  tws_core_s next_cq;
  logic [7:0] mem [0:tws_pkg::NUM_BYTES-1]; // RULE1
  logic [2:0] lk_m;
  logic [2:0] lk_s;
  logic organization_select;
  logic wen_s;
  logic busy_s;
  logic wr_one;
  logic wr_all;
  logic [6:0] wr_addr;
  logic [15:0] wr_data;

  // opcode of a frame, at address end or after the data
  function automatic logic [1:0] get_op(input logic [23:0] s, input logic o, input logic wdata);
    logic [23:0] t;
    t = wdata ? (o ? (s >> tws_pkg::DW_X16) : (s >> tws_pkg::DW_X8)) : s;
    get_op = o ? t[7:6] : t[8:7];
  endfunction : get_op

  // address of a frame, byte or word units
  function automatic logic [6:0] get_addr(input logic [23:0] s, input logic o, input logic wdata);
    logic [23:0] t;
    t = wdata ? (o ? (s >> tws_pkg::DW_X16) : (s >> tws_pkg::DW_X8)) : s;
    get_addr = o ? {1'b0, t[5:0]} : t[6:0];
  endfunction : get_addr

  // byte lane i belongs to the addressed location
  function automatic logic byte_hit(input int i, input logic o, input logic [6:0] a);
    logic [6:0] b;
    b = 7'(i);
    byte_hit = o ? (b[6:1] == a[5:0]) : (b == a); // RULE1
  endfunction : byte_hit

  // strap and status into the link domain
  always_ff @(posedge lnk.sk) begin
    lk_m <= {organization_select_i, cq.wen, cq.busy};
    lk_s <= lk_m;
  end
  assign organization_select = lk_s[2];
  assign wen_s = lk_s[1];
  assign busy_s = lk_s[0];

  // frame decoder on the shift clock
  always_comb begin
    logic [4:0] aw;
    logic [4:0] dw;
    logic ok;
    logic [1:0] op;
    logic [1:0] ext;
    logic [6:0] a;
    aw = organization_select ? 5'(tws_pkg::AW_X16) : 5'(tws_pkg::AW_X8);
    dw = organization_select ? 5'(tws_pkg::DW_X16) : 5'(tws_pkg::DW_X8);
    ok = wen_s & ~busy_s; // RULE11
    op = 2'h0;
    ext = 2'h0;
    a = 7'h00;
    next_fq = fq;
    wr_one = 1'b0;
    wr_all = 1'b0;
    wr_addr = 7'h00;
    wr_data = 16'h0000;
    if (!fq.started) begin
      next_fq.started = (lnk.di == tws_pkg::START_MARKER); // RULE19
    end else if (!fq.done) begin
      next_fq.sh = {fq.sh[22:0], lnk.di}; // RULE19
      next_fq.n = fq.n + 5'h01;
      if (next_fq.n == aw + 5'h02) begin
        op = get_op(next_fq.sh, organization_select, 1'b0);
        a = get_addr(next_fq.sh, organization_select, 1'b0);
        ext = organization_select ? a[5:4] : a[6:5];
        case (op)
          tws_pkg::TWS_OP_READ: begin
            next_fq.rd_act = 1'b1; // RULE2
            next_fq.rd_sh = organization_select ? {1'b0, mem[{a[5:0], 1'b0}], mem[{a[5:0], 1'b1}]} // RULE15
                                : {1'b0, mem[a], 8'h00};
            next_fq.done = 1'b1;
          end
          tws_pkg::TWS_OP_ERASE: begin
            wr_one = ok; // RULE4
            wr_addr = a;
            wr_data = {tws_pkg::ERASED_BYTE, tws_pkg::ERASED_BYTE}; // RULE17
            next_fq.go = ok;
            next_fq.done = 1'b1;
          end
          tws_pkg::TWS_OP_EXT: begin
            case (ext)
              tws_pkg::TWS_EXT_ENABLE: begin
                next_fq.en = 1'b1; // RULE3
                next_fq.done = 1'b1;
              end
              tws_pkg::TWS_EXT_DISABLE: begin
                next_fq.ds = 1'b1; // RULE8
                next_fq.done = 1'b1;
              end
              tws_pkg::TWS_EXT_ERASE_ALL: begin
                wr_all = ok; // RULE6
                wr_data = {tws_pkg::ERASED_BYTE, tws_pkg::ERASED_BYTE}; // RULE17
                next_fq.go = ok;
                next_fq.done = 1'b1;
              end
              default: begin
                next_fq.done = 1'b0;
              end
            endcase
          end
          default: begin
            next_fq.done = 1'b0;
          end
        endcase
      end else if (next_fq.n == aw + dw + 5'h02) begin
        op = get_op(next_fq.sh, organization_select, 1'b1);
        a = get_addr(next_fq.sh, organization_select, 1'b1);
        wr_addr = a;
        wr_data = organization_select ? next_fq.sh[15:0] : {next_fq.sh[7:0], next_fq.sh[7:0]};
        wr_one = ok & (op == tws_pkg::TWS_OP_WRITE); // RULE5
        wr_all = ok & (op == tws_pkg::TWS_OP_EXT); // RULE7
        next_fq.go = ok; // RULE10
        next_fq.done = 1'b1;
      end
    end else if (fq.rd_act) begin
      next_fq.rd_sh = {fq.rd_sh[15:0], 1'b0}; // RULE19
    end
  end

  // frame register, ended by the frame's own select
  always_ff @(posedge lnk.sk or negedge lnk.cs) begin
    if (!lnk.cs) begin
      fq <= '0;
    end else begin
      fq <= next_fq;
    end
  end

  // array update, overwrite without a prior erase
  always_ff @(posedge lnk.sk) begin
    for (int i = 0; i < tws_pkg::NUM_BYTES; i++) begin
      if (lnk.cs && (wr_all || (wr_one && byte_hit(i, organization_select, wr_addr)))) begin
        mem[i] <= (organization_select && !i[0]) ? wr_data[15:8] : wr_data[7:0]; // RULE10
      end
    end
  end

  // enable state, programming timer and data-out pin
  always_comb begin
    logic cs_s;
    cs_s = cq.s[5];
    next_cq = cq;
    next_cq.m = {lnk.cs, fq.go, fq.en, fq.ds, fq.rd_act, fq.rd_sh[16]};
    next_cq.s = cq.m;
    next_cq.cs_q = cs_s;
    next_cq.go_q = cq.s[4];
    next_cq.en_q = cq.s[3];
    next_cq.ds_q = cq.s[2];
    if (cq.s[3] && !cq.en_q) begin
      next_cq.wen = 1'b1; // RULE3
    end
    if (cq.s[2] && !cq.ds_q) begin
      next_cq.wen = 1'b0; // RULE8
    end
    if (cq.busy) begin
      next_cq.cnt = cq.cnt + 1'b1;
      if (cq.cnt == PROG_LAST) begin
        next_cq.busy = 1'b0; // RULE13
      end
    end
    if (!cs_s && cq.cs_q && !cq.busy) begin
      next_cq.stat = 1'b0;
    end
    if (cq.s[4] && !cq.go_q) begin
      next_cq.busy = 1'b1; // RULE10
      next_cq.cnt = '0;
      next_cq.stat = 1'b1; // RULE12
    end
    next_cq.oe_q = cs_s & (cq.stat | cq.s[1]);
    if (!cs_s) begin
      next_cq.do_q = 1'b0;
    end else if (cq.stat) begin
      next_cq.do_q = ~cq.busy; // RULE18
    end else begin
      next_cq.do_q = cq.s[1] & cq.s[0]; // RULE2
    end
  end

  // timing-domain register, power-up disabled
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      cq <= '0; // RULE16
    end else begin
      cq <= next_cq;
    end
  end

  // outputs
  assign lnk.do_val = cq.do_q;
  assign lnk.do_oe = cq.oe_q;
  assign busy_o = cq.busy;
endmodule : tws_eeprom_dev

/* core/tws_host_ctrl.sv */
// host end of the three-wire link: frames commands, polls status, buffers results
`timescale 1ns/1ps
module tws_host_ctrl #(
  parameter int HALF_CYCLES = tws_pkg::SK_HALF_CYC,
  parameter int POLL_TIMEOUT = tws_pkg::TWP_MAX_CYC
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // link
  tws_link_if.host lnk,
  // organisation of the attached array
  input wire logic organization_select_i,
  // command
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic [2:0] cmd_op_i,
  input wire logic [6:0] cmd_addr_i,
  input wire logic [15:0] cmd_data_i,
  // result
  output logic res_valid_o,
  input wire logic res_ready_i,
  output logic [15:0] res_data_o,
  output logic res_ok_o
);
  localparam int TW = $clog2(POLL_TIMEOUT + 1);
  localparam logic [7:0] HALF_LAST = 8'(HALF_CYCLES - 1);
  localparam logic [7:0] TCS_LAST = 8'(tws_pkg::TCS_CYC - 1);
  localparam logic [TW-1:0] TSV_WAIT = TW'(tws_pkg::TSV_CYC);
  localparam logic [TW-1:0] POLL_LAST = TW'(POLL_TIMEOUT - 1);

  typedef enum logic [2:0] {
    TWS_H_IDLE = 3'b000,
    TWS_H_LOW = 3'b001,
    TWS_H_HIGH = 3'b010,
    TWS_H_GAP = 3'b011,
    TWS_H_POLL = 3'b100,
    TWS_H_PUSH = 3'b101
  } tws_hst_e;

  typedef struct packed {
    tws_hst_e st;
    logic [7:0] cnt;
    logic [TW-1:0] tcnt;
    logic cs;
    logic sk;
    logic di;
    logic [tws_pkg::FRAME_W-1:0] tx;
    logic [4:0] left;
    logic [4:0] rxn;
    logic [16:0] rx;
    logic poll;
    logic organization_select;
    logic [1:0] org_sy;
    logic ok;
    logic [1:0] ds;
    logic rdy;
    logic v0;
    logic [16:0] d0;
    logic v1;
    logic [16:0] d1;
  } tws_host_s;

  tws_host_s q;
  tws_host_s next_q;

  // sequencer and two-entry result buffer
  always_comb begin
    logic [1:0] op;
    logic [6:0] a;
    logic [16:0] res;
    logic pop;
    logic org_s;
    logic [5:0] wa;
    op = tws_pkg::TWS_OP_EXT;
    a = cmd_addr_i;
    res = {q.ok, q.organization_select ? q.rx[15:0] : {8'h00, q.rx[7:0]}};
    pop = q.v0 & res_ready_i;
    org_s = q.org_sy[1];
    wa = 6'h00;
    next_q = q;
    // strap pin through two flops before use
    next_q.org_sy = {q.org_sy[0], organization_select_i};
    next_q.ds = {q.ds[0], lnk.do_line};
    next_q.cnt = q.cnt + 8'h01;
    if (pop) begin
      next_q.v0 = q.v1;
      next_q.d0 = q.d1;
      next_q.v1 = 1'b0;
    end
    case (q.st)
      TWS_H_IDLE: begin
        next_q.cnt = 8'h00;
        if (cmd_valid_i && q.rdy) begin
          case (cmd_op_i)
            tws_pkg::TWS_CMD_READ: op = tws_pkg::TWS_OP_READ;
            tws_pkg::TWS_CMD_ERASE: op = tws_pkg::TWS_OP_ERASE;
            tws_pkg::TWS_CMD_WRITE: op = tws_pkg::TWS_OP_WRITE;
            default: op = tws_pkg::TWS_OP_EXT;
          endcase
          case (cmd_op_i)
            tws_pkg::TWS_CMD_ENABLE: a = {tws_pkg::TWS_EXT_ENABLE, 5'h00};
            tws_pkg::TWS_CMD_DISABLE: a = {tws_pkg::TWS_EXT_DISABLE, 5'h00};
            tws_pkg::TWS_CMD_ERASE_ALL: a = {tws_pkg::TWS_EXT_ERASE_ALL, 5'h00};
            tws_pkg::TWS_CMD_WRITE_ALL: a = {tws_pkg::TWS_EXT_WRITE_ALL, 5'h00};
            default: a = cmd_addr_i;
          endcase
          // word mode: extended codes sit in the top two of six bits, addresses in [5:0]
          wa = (op == tws_pkg::TWS_OP_EXT) ? a[6:1] : a[5:0];
          next_q.organization_select = org_s;
          next_q.tx = org_s
                    ? {tws_pkg::START_MARKER, op, wa, cmd_data_i, 2'b00}
                    : {tws_pkg::START_MARKER, op, a, cmd_data_i[7:0], 9'h000};
          next_q.left = (org_s ? 5'(3 + tws_pkg::AW_X16) : 5'(3 + tws_pkg::AW_X8))
                      + (((cmd_op_i == tws_pkg::TWS_CMD_WRITE) || (cmd_op_i == tws_pkg::TWS_CMD_WRITE_ALL))
                      ? (org_s ? 5'(tws_pkg::DW_X16) : 5'(tws_pkg::DW_X8)) : 5'h00); // RULE9
          next_q.rxn = (cmd_op_i == tws_pkg::TWS_CMD_READ)
                     ? (org_s ? 5'(tws_pkg::DW_X16 + 1) : 5'(tws_pkg::DW_X8 + 1)) : 5'h00;
          next_q.poll = (cmd_op_i >= tws_pkg::TWS_CMD_ERASE);
          next_q.di = tws_pkg::START_MARKER;
          next_q.cs = 1'b1;
          next_q.rx = 17'h00000;
          next_q.ok = 1'b1;
          next_q.rdy = 1'b0;
          next_q.st = TWS_H_LOW;
        end
      end
      TWS_H_LOW: begin
        if (q.cnt == HALF_LAST) begin
          next_q.cnt = 8'h00;
          next_q.sk = 1'b1; // RULE19
          next_q.st = TWS_H_HIGH;
          if (q.left != 5'h00) begin
            next_q.left = q.left - 5'h01;
            next_q.tx = {q.tx[tws_pkg::FRAME_W-2:0], 1'b0};
          end else begin
            next_q.rx = {q.rx[15:0], q.ds[1]}; // RULE15
            next_q.rxn = q.rxn - 5'h01;
          end
        end
      end
      TWS_H_HIGH: begin
        if (q.cnt == HALF_LAST) begin
          next_q.cnt = 8'h00;
          next_q.sk = 1'b0; // RULE14
          next_q.di = (q.left != 5'h00) ? q.tx[tws_pkg::FRAME_W-1] : 1'b0;
          if ((q.left != 5'h00) || (q.rxn != 5'h00)) begin
            next_q.st = TWS_H_LOW;
          end else begin
            next_q.cs = 1'b0;
            next_q.st = TWS_H_GAP;
          end
        end
      end
      TWS_H_GAP: begin
        if (q.cnt == TCS_LAST) begin
          next_q.tcnt = '0;
          if (q.poll) begin
            next_q.cs = 1'b1; // RULE12
            next_q.poll = 1'b0;
            next_q.st = TWS_H_POLL;
          end else begin
            next_q.st = TWS_H_PUSH;
          end
        end
      end
      TWS_H_POLL: begin
        next_q.tcnt = q.tcnt + 1'b1;
        if ((q.tcnt >= TSV_WAIT) && q.ds[1]) begin
          next_q.cs = 1'b0; // RULE18
          next_q.cnt = 8'h00;
          next_q.st = TWS_H_GAP;
        end else if (q.tcnt == POLL_LAST) begin
          next_q.cs = 1'b0; // RULE13
          next_q.ok = 1'b0;
          next_q.cnt = 8'h00;
          next_q.st = TWS_H_GAP;
        end
      end
      TWS_H_PUSH: begin
        if (!next_q.v0) begin
          next_q.v0 = 1'b1;
          next_q.d0 = res;
          next_q.rdy = 1'b1;
          next_q.st = TWS_H_IDLE;
        end else if (!next_q.v1) begin
          next_q.v1 = 1'b1;
          next_q.d1 = res;
          next_q.rdy = 1'b1;
          next_q.st = TWS_H_IDLE;
        end
      end
      default: begin
        next_q.st = TWS_H_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      q <= '0;
      q.rdy <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // outputs
  assign lnk.cs = q.cs;
  assign lnk.sk = q.sk;
  assign lnk.di = q.di;
  assign cmd_ready_o = q.rdy;
  assign res_valid_o = q.v0;
  assign res_data_o = q.d0[15:0];
  assign res_ok_o = q.d0[16];
endmodule : tws_host_ctrl

/* bench/tws_link_sva.sv */
// checker for timing and framing on the three-wire link
`timescale 1ns/1ps
module tws_link_sva (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // link signals
  input wire logic cs,
  input wire logic sk,
  input wire logic di,
  input wire logic do_val,
  input wire logic do_oe,
  input wire logic do_line,
  // strap: high selects 16-bit words
  input wire logic organization_select_i
);
  localparam int MIN_HALF = 12;
  logic sk_q;
  logic cs_q;
  logic [7:0] sk_run;
  logic [7:0] cs_run;
  logic [4:0] bits;
  logic [8:0] sr;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  // run lengths of sk and cs, bit count and first bits of a frame
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      sk_q <= 1'b0;
      cs_q <= 1'b0;
      sk_run <= 8'h00;
      cs_run <= 8'h00;
      bits <= 5'h00;
      sr <= 9'h000;
    end else begin
      sk_q <= sk;
      cs_q <= cs;
      sk_run <= (sk != sk_q) ? 8'h00 : sk_run + 8'((sk_run != 8'hff) ? 1 : 0);
      cs_run <= (cs != cs_q) ? 8'h00 : cs_run + 8'((cs_run != 8'hff) ? 1 : 0);
      bits <= !cs ? 5'h00 : bits + 5'((sk && !sk_q) ? 1 : 0);
      sr <= !cs ? 9'h000 : ((sk && !sk_q) ? {sr[7:0], di} : sr);
    end
  end
  a_sk_half_time: assert property ((sk != sk_q) |-> sk_run >= MIN_HALF)
    else $error("shift clock phase too short");
  a_cs_low_time: assert property ((cs && !cs_q) |-> cs_run >= MIN_HALF)
    else $error("select low time too short");
  a_sk_idle_low: assert property (!cs |-> !sk)
    else $error("shift clock moves outside a frame");
  a_di_held_high: assert property ((sk && sk_q) |-> $stable(di))
    else $error("serial in changes while shift clock high");
  a_start_bit_first: assert property ((sk && !sk_q && cs && bits == 5'd0) |-> di)
    else $error("frame does not open with the start marker");
  a_read_dummy_zero: assert property ((sk && !sk_q && cs && (organization_select_i
      ? (bits == 5'd8 && sr[7:5] == 3'b110) : (bits == 5'd9 && sr[8:6] == 3'b110))) |-> ##4 (do_oe && !do_val))
    else $error("no zero dummy bit before read data");
  // host reads sample before each rise, so a read takes one rise past the last data bit
  a_frame_full_len: assert property ((!cs && cs_q) |-> (bits == 5'd0 || (organization_select_i
      ? (bits == 5'd9 || bits == 5'd25 || bits == 5'd26) : (bits == 5'd10 || bits == 5'd18 || bits == 5'd19))))
    else $error("frame not sent at full length");
  a_do_released: assert property (!cs [*4] |-> !do_oe)
    else $error("data out driven with select low");
  a_poll_ends_ready: assert property ((!cs && cs_q && bits == 5'd0) |-> $past(do_line))
    else $error("status poll ended without ready");
endmodule : tws_link_sva

/* bench/tb_three_wire_serial_eeprom_1k.sv */
// self-checking bench: host controller and eeprom joined across the link
`timescale 1ns/1ps
module tb_three_wire_serial_eeprom_1k;
  localparam logic [16:0] ERASED = 17'h1ffff;
  logic core_clk_i;
  logic rstn_i;
  logic organization_select;
  logic cmd_valid_i;
  logic cmd_ready_o;
  logic [2:0] cmd_op_i;
  logic [6:0] cmd_addr_i;
  logic [15:0] cmd_data_i;
  logic res_valid_o;
  logic res_ready_i;
  logic [15:0] res_data_o;
  logic res_ok_o;
  logic busy_o;
  logic [16:0] exp_q[$];
  logic [16:0] e;
  logic stall;
  logic busy_seen;
  logic [6:0] a;
  logic [15:0] d;
  int bad_count;
  int total_checks;
  int cycles;
  tws_link_if lnk ();
  tws_host_ctrl #(.POLL_TIMEOUT(200)) u_tws_host_ctrl (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .lnk(lnk), .organization_select_i(organization_select),
    .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i),
    .cmd_data_i(cmd_data_i), .res_valid_o(res_valid_o), .res_ready_i(res_ready_i), .res_data_o(res_data_o),
    .res_ok_o(res_ok_o));
  tws_eeprom_dev #(.PROG_CYCLES(50)) u_tws_eeprom_dev (
    .lnk(lnk), .core_clk_i(core_clk_i), .rstn_i(rstn_i), .organization_select_i(organization_select), .busy_o(busy_o));
  tws_link_sva u_tws_link_sva (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .cs(lnk.cs), .sk(lnk.sk), .di(lnk.di),
    .do_val(lnk.do_val), .do_oe(lnk.do_oe), .do_line(lnk.do_line), .organization_select_i(organization_select));
  // clock
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask : check
  // one command, held until taken; expectation noted on the way
  task automatic send(input tws_pkg::tws_cmd_e op, input logic [6:0] ad, input logic [15:0] dt, input logic [16:0] ex);
    @(negedge core_clk_i);
    while (cmd_ready_o !== 1'b1) @(negedge core_clk_i);
    cmd_op_i = op;
    cmd_addr_i = ad;
    cmd_data_i = dt;
    cmd_valid_i = 1'b1;
    exp_q.push_back(ex);
    @(negedge core_clk_i);
    cmd_valid_i = 1'b0;
  endtask : send
  task automatic drain(input string name);
    while (exp_q.size() != 0) @(negedge core_clk_i);
    $display("test %0s done", name);
  endtask : drain
  task automatic do_reset();
    rstn_i = 1'b0;
    repeat (12) @(negedge core_clk_i);
    rstn_i = 1'b1;
    repeat (20) @(negedge core_clk_i);
  endtask : do_reset
  // result watcher: compares results and drives back-pressure
  // ready is chosen first, so a taken result is compared while it still stands
  always @(negedge core_clk_i) begin
    res_ready_i = stall ? 1'b0 : 1'(($urandom & 3) != 0);
    if (busy_o === 1'b1) busy_seen = 1'b1;
    if (busy_o === 1'b1 && lnk.do_oe === 1'b1) check({15'h0, lnk.do_line}, 16'h0000);
    if (res_valid_o === 1'b1 && res_ready_i === 1'b1) begin
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("[ERR] %0t unexpected result", $time);
      end else begin
        e = exp_q.pop_front();
        check({15'h0, res_ok_o}, 16'h0001);
        if (e[16]) check(res_data_o, e[15:0]);
      end
    end
  end
  // hang guard
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    rstn_i = 1'b0;
    organization_select = 1'b1;
    cmd_valid_i = 1'b0;
    cmd_op_i = 3'h0;
    cmd_addr_i = 7'h00;
    cmd_data_i = 16'h0000;
    res_ready_i = 1'b0;
    stall = 1'b0;
    busy_seen = 1'b0;
    bad_count = 0;
    total_checks = 0;
    cycles = 0;
    void'($urandom(32'h0a42));
    do_reset();
    // erase all, then programming refused once disabled
    send(tws_pkg::TWS_CMD_ENABLE, 7'h00, 16'h0000, 17'h0);
    send(tws_pkg::TWS_CMD_ERASE_ALL, 7'h00, 16'h0000, 17'h0);
    send(tws_pkg::TWS_CMD_READ, 7'h00, 16'h0000, ERASED);
    send(tws_pkg::TWS_CMD_DISABLE, 7'h00, 16'h0000, 17'h0);
    send(tws_pkg::TWS_CMD_WRITE, 7'h00, 16'(($urandom)), 17'h0);
    send(tws_pkg::TWS_CMD_READ, 7'h00, 16'h0000, ERASED);
    drain("disable");
    // a fresh reset leaves programming disabled
    do_reset();
    send(tws_pkg::TWS_CMD_WRITE, 7'h3f, 16'h0000, 17'h0);
    send(tws_pkg::TWS_CMD_READ, 7'h3f, 16'h0000, ERASED);
    drain("power_up");
    // random writes with read-back, then overwrite without erase
    send(tws_pkg::TWS_CMD_ENABLE, 7'h40, 16'h0000, 17'h0);
    for (int i = 0; i < 5; i++) begin
      a = 7'($urandom_range(0, 63));
      d = 16'($urandom);
      if (i == 4) a = 7'h3f;
      send(tws_pkg::TWS_CMD_WRITE, a, d, 17'h0);
      send(tws_pkg::TWS_CMD_READ, a, 16'h0000, {1'b1, d});
      send(tws_pkg::TWS_CMD_WRITE, a, ~d, 17'h0);
      send(tws_pkg::TWS_CMD_READ, a, 16'h0000, {1'b1, ~d});
    end
    drain("write");
    send(tws_pkg::TWS_CMD_ERASE, a, 16'h0000, 17'h0);
    send(tws_pkg::TWS_CMD_READ, a, 16'h0000, ERASED);
    d = 16'($urandom);
    send(tws_pkg::TWS_CMD_WRITE_ALL, 7'h00, d, 17'h0);
    send(tws_pkg::TWS_CMD_READ, 7'h00, 16'h0000, {1'b1, d});
    send(tws_pkg::TWS_CMD_READ, 7'h2a, 16'h0000, {1'b1, d});
    drain("erase_write_all");
    check({15'h0, busy_seen}, 16'h0001);
    // results held in the buffer while the reader stalls
    stall = 1'b1;
    repeat (3) send(tws_pkg::TWS_CMD_READ, 7'h15, 16'h0000, {1'b1, d});
    repeat (1500) @(negedge core_clk_i);
    check({15'h0, cmd_ready_o}, 16'h0000);
    stall = 1'b0;
    drain("buffer");
    // byte organisation: strap low across a reset, neighbouring bytes kept apart
    organization_select = 1'b0;
    do_reset();
    send(tws_pkg::TWS_CMD_ENABLE, 7'h00, 16'h0000, 17'h0);
    d = 16'($urandom);
    send(tws_pkg::TWS_CMD_WRITE, 7'h55, d, 17'h0);
    send(tws_pkg::TWS_CMD_WRITE, 7'h54, ~d, 17'h0);
    send(tws_pkg::TWS_CMD_READ, 7'h55, 16'h0000, {9'h100, d[7:0]});
    send(tws_pkg::TWS_CMD_READ, 7'h54, 16'h0000, {9'h100, ~d[7:0]});
    drain("byte_mode");
    report_and_stop();
  end
endmodule : tb_three_wire_serial_eeprom_1k
